//--- logic/afe_config.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "afe_params.svh"

module afe_config (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire afe_pkg::afe_sample_s sample_in_ch0,
  input wire afe_pkg::afe_sample_s sample_in_ch1,
  output afe_pkg::afe_sample_s sample_out_ch0,
  output afe_pkg::afe_sample_s sample_out_ch1,
  output afe_pkg::afe_ctrl_s ctrl_ch0,
  output afe_pkg::afe_ctrl_s ctrl_ch1,
  output logic [7:0] reference_trim_code
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------

  // Reserved codes fall through to unity gain so a stray write never
  // leaves the amplifier at an undefined setting.
  function automatic afe_pkg::afe_gain_value_t decode_gain(
    input afe_pkg::afe_gain_code_t code
  );
    afe_pkg::afe_gain_value_t v;
    v = `AFE_GV_X1;
    case (code)
      `AFE_GC_X1: v = `AFE_GV_X1;
      `AFE_GC_X2: v = `AFE_GV_X2;
      `AFE_GC_X4: v = `AFE_GV_X4;
      `AFE_GC_X8: v = `AFE_GV_X8;
      `AFE_GC_X16: v = `AFE_GV_X16;
      `AFE_GC_X32: v = `AFE_GV_X32;
      default: v = `AFE_GV_X1;
    endcase
    return v;
  endfunction : decode_gain

  function automatic afe_pkg::afe_ctrl_s build_ctrl(
    input afe_pkg::afe_gain_code_t code,
    input logic srst,
    input logic pdn
  );
    afe_pkg::afe_ctrl_s c;
    c.gain = decode_gain(code);
    c.bias_en = ~pdn;
    c.clk_en = ~pdn;
    c.digital_en = ~pdn;
    c.zero_out = srst;
    return c;
  endfunction : build_ctrl

  // Gated sample: silent while powered down, zero data while in soft reset.
  function automatic afe_pkg::afe_sample_s gate_sample(
    input afe_pkg::afe_sample_s s,
    input afe_pkg::afe_ctrl_s c
  );
    afe_pkg::afe_sample_s o;
    o.valid = s.valid & c.clk_en;
    o.data = c.zero_out ? `AFE_SAMPLE_ZERO : s.data;
    if (!c.digital_en) begin
      o.data = `AFE_SAMPLE_ZERO;
    end
    return o;
  endfunction : gate_sample

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [31:0] prdata_q;
  wire logic cfg_hit;
  wire logic setup_phase;
  wire logic access_phase;
  wire logic cfg_write;
  wire logic [31:0] byte_mask;
  wire logic [31:0] cfg_d;
  wire logic [31:0] rd_value;

  assign cfg_hit = (paddr == `AFE_CFG_ADDR);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign cfg_write = access_phase & pwrite & cfg_hit;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Only implemented bits take the write; the rest stay zero.
  assign cfg_d = (cfg_q & ~(byte_mask & `AFE_CFG_WMASK)) |
                 (pwdata & byte_mask & `AFE_CFG_WMASK);

  // Read data is captured in the setup cycle, so the access cycle never
  // waits and pready can stay high.
  assign rd_value = (cfg_hit && !pwrite) ? cfg_q : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = access_phase & ~cfg_hit;

  // --------------------------------------------------------------------------
  // Configuration word
  // --------------------------------------------------------------------------

  // The word changes only by reset or a bus write; nothing else enters soft reset
  // or power-down.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= `AFE_CFG_RESET;
    end else if (cfg_write) begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_q <= rd_value;
    end
  end

  assign prdata = prdata_q;

  // --------------------------------------------------------------------------
  // Field extraction
  // --------------------------------------------------------------------------
  wire afe_pkg::afe_gain_code_t gain_select_ch0;
  wire afe_pkg::afe_gain_code_t gain_select_ch1;
  wire logic [1:0] soft_reset;
  wire logic [1:0] power_down;

  assign gain_select_ch0 = cfg_q[`AFE_GAIN0_HI:`AFE_GAIN0_LO];
  assign gain_select_ch1 = cfg_q[`AFE_GAIN1_HI:`AFE_GAIN1_LO];
  assign soft_reset = cfg_q[`AFE_SRST_HI:`AFE_SRST_LO];
  assign power_down = cfg_q[`AFE_PDN_HI:`AFE_PDN_LO];
  assign reference_trim_code = cfg_q[`AFE_TRIM_HI:`AFE_TRIM_LO];

  // --------------------------------------------------------------------------
  // Converter controls
  // --------------------------------------------------------------------------

  // Controls are decoded combinationally from the stored word, so they change just after the
  // write edge; the gain passes through decode_gain and is not a flop output.
  assign ctrl_ch0 = build_ctrl(gain_select_ch0, soft_reset[0], power_down[0]);
  assign ctrl_ch1 = build_ctrl(gain_select_ch1, soft_reset[1], power_down[1]);

  // --------------------------------------------------------------------------
  // Sample path
  // --------------------------------------------------------------------------
  afe_pkg::afe_sample_s out0_q;
  afe_pkg::afe_sample_s out1_q;

  // Samples pass with one cycle of latency; the converter keeps running
  // in soft reset, only its result is masked.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out0_q <= '0;
      out1_q <= '0;
    end else begin
      out0_q <= gate_sample(sample_in_ch0, ctrl_ch0);
      out1_q <= gate_sample(sample_in_ch1, ctrl_ch1);
    end
  end

  assign sample_out_ch0 = out0_q;
  assign sample_out_ch1 = out1_q;

endmodule : afe_config

//--- logic/afe_params.svh
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define AFE_CFG_INDEX 10'h042
`define AFE_CFG_ADDR {`AFE_CFG_INDEX, 2'b00}
`define AFE_CFG_RESET 32'h0042_0000
`define AFE_CFG_WMASK 32'h3fff_000f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AFE_GAIN1_HI 29
`define AFE_GAIN1_LO 27
`define AFE_GAIN0_HI 26
`define AFE_GAIN0_LO 24
`define AFE_TRIM_HI 23
`define AFE_TRIM_LO 16
`define AFE_SRST_HI 3
`define AFE_SRST_LO 2
`define AFE_PDN_HI 1
`define AFE_PDN_LO 0

// ----------------------------------------------------------------------------
// Gain encodings
// ----------------------------------------------------------------------------
`define AFE_GC_X1 3'h0
`define AFE_GC_X2 3'h1
`define AFE_GC_X4 3'h2
`define AFE_GC_X8 3'h3
`define AFE_GC_X16 3'h4
`define AFE_GC_X32 3'h5
`define AFE_GV_X1 6'h01
`define AFE_GV_X2 6'h02
`define AFE_GV_X4 6'h04
`define AFE_GV_X8 6'h08
`define AFE_GV_X16 6'h10
`define AFE_GV_X32 6'h20

`define AFE_SAMPLE_W 24
`define AFE_SAMPLE_ZERO 24'h00_0000

`endif

//--- logic/afe_pkg.sv
package afe_pkg;

  typedef logic [2:0] afe_gain_code_t;
  typedef logic [5:0] afe_gain_value_t;

  // One converter sample with its valid flag.
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } afe_sample_s;

  // Analog controls for one converter and its amplifier.
  typedef struct packed {
    afe_gain_value_t gain;
    logic bias_en;
    logic clk_en;
    logic digital_en;
    logic zero_out;
  } afe_ctrl_s;

endpackage : afe_pkg

//--- testbench/afe_config_chk.sv
`timescale 1ns/10ps
module afe_config_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire afe_pkg::afe_sample_s sample_in_ch0,
  input wire afe_pkg::afe_sample_s sample_out_ch0,
  input wire afe_pkg::afe_ctrl_s ctrl_ch0,
  input wire afe_pkg::afe_ctrl_s ctrl_ch1,
  input wire logic [7:0] reference_trim_code
);
  wire wa = psel && penable && pwrite && paddr == 12'h108;
  // Only full-word writes let a field be predicted from pwdata alone.
  wire wr = wa && pstrb == 4'hf;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  trim_load_a: assert property (wr |=> reference_trim_code == $past(pwdata[23:16]))
    else $error("trim code not loaded");
  gain_decode_a: assert property (wr && pwdata[26:24] < 3'h6 |=>
    ctrl_ch0.gain == 6'h01 << $past(pwdata[26:24])) else $error("gain decode wrong");
  gain_unused_a: assert property (wr && pwdata[29:28] == 2'h3 |=> ctrl_ch1.gain == 6'h01)
    else $error("unused gain code not one");
  soft_reset_a: assert property (wr |=> ctrl_ch1.zero_out == $past(pwdata[3]))
    else $error("soft reset control wrong");
  pdn_ctrl_a: assert property (wr |=> ctrl_ch0.bias_en == !$past(pwdata[0]))
    else $error("power down control wrong");
  pdn_wake_a: assert property (ctrl_ch0.bias_en |-> ctrl_ch0.clk_en && ctrl_ch0.digital_en)
    else $error("wake controls split");
  cfg_hold_a: assert property (nrst && !wa |=> $stable(ctrl_ch0) && $stable(ctrl_ch1)
    && $stable(reference_trim_code)) else $error("controls moved without write");
  zero_out_a: assert property (nrst |=> sample_out_ch0.data ==
    (($past(ctrl_ch0.zero_out) || !$past(ctrl_ch0.bias_en)) ? 24'h0 : $past(sample_in_ch0.data)))
    else $error("sample data wrong");
  pdn_valid_a: assert property (nrst |=> sample_out_ch0.valid ==
    ($past(sample_in_ch0.valid) && $past(ctrl_ch0.bias_en))) else $error("sample valid wrong");
  bad_addr_a: assert property (psel && penable && paddr != 12'h108 |-> pslverr)
    else $error("unmapped access not flagged");
endmodule : afe_config_chk

bind afe_config afe_config_chk chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pslverr, .sample_in_ch0, .sample_out_ch0, .ctrl_ch0, .ctrl_ch1, .reference_trim_code);

//--- testbench/afe_config_tb_top.sv
`timescale 1ns/10ps
module afe_config_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  afe_pkg::afe_sample_s si = '0;
  afe_pkg::afe_sample_s so0;
  afe_pkg::afe_ctrl_s c0;
  afe_pkg::afe_ctrl_s c1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] trim;
  int n_mismatch = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  afe_config uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .sample_in_ch0(si), .sample_in_ch1(si), .sample_out_ch0(so0),
    .sample_out_ch1(), .ctrl_ch0(c0), .ctrl_ch1(c1), .reference_trim_code(trim));
  // --------------------
  // Tasks
  // --------------------
  task automatic close_out;
    $display("mismatches %0d checked %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : cmp
  // The wait is bounded so a slave that never answers still reaches the report.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask : apb
  task automatic smp(input string what, input logic [24:0] e);
    @(posedge clk);
    si <= {1'b1, 24'habcdef};
    @(posedge clk);
    si <= '0;
    @(negedge clk);
    cmp(what, {7'h0, e}, {7'h0, so0});
  endtask : smp
  function automatic logic [31:0] gv(input int c);
    return c < 6 ? 32'h1 << c : 32'h1;
  endfunction : gv
  initial begin
    logic [31:0] q;
    logic err;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 12'h108, 32'h0, q, err);
    cmp("reset word", 32'h0042_0000, q);
    cmp("reset trim", 32'h42, {24'h0, trim});
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h108, {2'h0, 3'(7 - k), 3'(k), 8'h5a, 16'h0000}, q, err);
      cmp("gain ch0", gv(k), {26'h0, c0.gain});
      cmp("gain ch1", gv(7 - k), {26'h0, c1.gain});
    end
    cmp("trim", 32'h5a, {24'h0, trim});
    apb(1'b1, 12'h10c, 32'hffff_ffff, q, err);
    cmp("bad write err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h000, 32'h0, q, err);
    cmp("bad read", 32'h0, q);
    cmp("bad read err", 32'h1, {31'h0, err});
    apb(1'b1, 12'h108, 32'hffff_ffff, q, err);
    apb(1'b0, 12'h108, 32'h0, q, err);
    cmp("masked word", 32'h3fff_000f, q);
    cmp("ctrl off", 32'h1, {28'h0, c0.bias_en, c0.clk_en, c0.digital_en, c0.zero_out});
    smp("sample off", 25'h0);
    apb(1'b1, 12'h108, 32'h0000_000c, q, err);
    cmp("ctrl on", 32'hf, {28'h0, c1.bias_en, c1.clk_en, c1.digital_en, c1.zero_out});
    smp("sample zero", {1'b1, 24'h0});
    apb(1'b1, 12'h108, 32'h0000_0000, q, err);
    smp("sample pass", {1'b1, 24'habcdef});
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 12'h108, 32'h0, q, err);
    cmp("second reset", 32'h0042_0000, q);
    close_out();
  end
endmodule : afe_config_tb_top
